// File: dcr_regs.sv
// Added by the designer: the Avalon-MM interface to the registers.
`include "dcr_params.svh"

// What this block does
// - Drive register at 0x21: bits 15:11 writable code, reset zero, 5:0 read zero.
// - Programmed code drives channel 3 settling and conversion only when override set.
// - Bits 10:6 read-only calibrated code; writes to them are ignored.
// - Calibrated code refreshed per amplitude correction unless auto-amplitude disabled.
// - Maker identification at 0x7E returns fixed 16-bit code, writes ignored.
// - Part identification at 0x7F returns fixed 8-bit code, writes ignored.
module dcr_regs #(
	parameter logic [15:0] MAKER_ID = `DCR_MAKER_ID_VAL,
	parameter logic [7:0]  PART_ID  = `DCR_PART_ID_VAL
) (
	input  wire logic        mclk_i,
	input  wire logic        rst_b_i,
	input  wire logic [8:0]  avs_address_i,
	input  wire logic        avs_read_i,
	input  wire logic        avs_write_i,
	input  wire logic [31:0] avs_writedata_i,
	input  wire logic [3:0]  avs_byteenable_i,
	output logic      [31:0] avs_readdata_o,
	output logic             avs_waitrequest_o,
	input  wire logic        ch3_active_i,
	input  wire logic        amp_corr_done_i,
	input  wire logic [4:0]  amp_corr_code_i,
	input  wire logic [4:0]  ch3_auto_code_i,
	output logic      [4:0]  ch3_drive_o,
	output logic             calibration_override_enable_o,
	output logic             auto_amplitude_disable_o
);

	// ----------------------------------------
	// State
	// ----------------------------------------
	dcr_pkg::dcr_state_e state_q, state_d;
	logic [31:0] rdata_q, rdata_d;
	logic [4:0]  drive_code_q, drive_code_d;
	logic [4:0]  cal_code_q, cal_code_d;
	logic        override_q, override_d;
	logic        autoamp_dis_q, autoamp_dis_d;
	logic [4:0]  drive_q, drive_d;
	logic        waitreq_q, waitreq_d;
	localparam logic [1:0] CFG_RST = `DCR_CFG_RST;

	logic [6:0]  idx;
	logic        take;
	logic        commit;
	logic        wr_lo;
	logic        wr_hi;

	// Register hit gated by its byte lane
	function automatic logic lane_hit(
		input logic [6:0] i,
		input logic [6:0] target,
		input logic       lane
	);
		return lane && (i == target);
	endfunction : lane_hit

	function automatic logic [31:0] read_mux(input logic [6:0] i);
		logic [31:0] r;
		r = 32'h0000_0000;
		unique case (i)
			`DCR_IDX_CH3_DRIVE: begin
				r[`DCR_DRIVE_CODE_MSB:`DCR_DRIVE_CODE_LSB] = drive_code_q;
				r[`DCR_CAL_CODE_MSB:`DCR_CAL_CODE_LSB]     = cal_code_q;
			end
			`DCR_IDX_MAKER_ID: r[15:0] = MAKER_ID;
			`DCR_IDX_PART_ID:  r[7:0]  = PART_ID;
			`DCR_IDX_CONFIG: begin
				r[`DCR_CFG_OVERRIDE_BIT] = override_q;
				r[`DCR_CFG_AUTOAMP_BIT]  = autoamp_dis_q;
			end
			default: r = 32'h0000_0000;
		endcase
		return r;
	endfunction : read_mux

	// ----------------------------------------
	// Request decode
	// ----------------------------------------
	always_comb begin
		idx    = avs_address_i[8:2];
		take   = (avs_read_i || avs_write_i) && (state_q == dcr_pkg::DCR_IDLE);
		// Writes land on the edge that sees waitrequest low
		commit = avs_write_i && (state_q == dcr_pkg::DCR_RESP);
		wr_lo  = commit && avs_byteenable_i[0];
		wr_hi  = commit && avs_byteenable_i[1];
	end

	// ----------------------------------------
	// Bus handshake
	// ----------------------------------------
	always_comb begin
		state_d   = state_q;
		waitreq_d = waitreq_q;
		rdata_d   = rdata_q;
		unique case (state_q)
			dcr_pkg::DCR_IDLE: begin
				// Read data captured here, stands for the answer cycle
				if (take) begin
					state_d   = dcr_pkg::DCR_RESP;
					waitreq_d = 1'b0;
					rdata_d   = avs_read_i ? read_mux(idx) : 32'h0000_0000;
				end
			end
			dcr_pkg::DCR_RESP: begin
				state_d   = dcr_pkg::DCR_IDLE;
				waitreq_d = 1'b1;
				rdata_d   = 32'h0000_0000;
			end
			default: begin
				// Illegal code falls back to idle
				state_d   = dcr_pkg::DCR_IDLE;
				waitreq_d = 1'b1;
				rdata_d   = 32'h0000_0000;
			end
		endcase
	end

	always_ff @(posedge mclk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			state_q   <= dcr_pkg::DCR_IDLE;
			waitreq_q <= 1'b1;
			rdata_q   <= 32'h0000_0000;
		end else begin
			state_q   <= state_d;
			waitreq_q <= waitreq_d;
			rdata_q   <= rdata_d;
		end
	end

	// ----------------------------------------
	// Configuration bits
	// ----------------------------------------
	always_comb begin
		override_d    = override_q;
		autoamp_dis_d = autoamp_dis_q;
		if (lane_hit(idx, `DCR_IDX_CONFIG, wr_lo)) begin
			override_d    = avs_writedata_i[`DCR_CFG_OVERRIDE_BIT];
			autoamp_dis_d = avs_writedata_i[`DCR_CFG_AUTOAMP_BIT];
		end
	end

	always_ff @(posedge mclk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			override_q    <= CFG_RST[`DCR_CFG_OVERRIDE_BIT];
			autoamp_dis_q <= CFG_RST[`DCR_CFG_AUTOAMP_BIT];
		end else begin
			override_q    <= override_d;
			autoamp_dis_q <= autoamp_dis_d;
		end
	end

	// ----------------------------------------
	// Programmed drive code
	// ----------------------------------------
	always_comb begin
		drive_code_d = drive_code_q;
		// Only the upper field has a write path
		if (lane_hit(idx, `DCR_IDX_CH3_DRIVE, wr_hi)) begin
			drive_code_d = avs_writedata_i[`DCR_DRIVE_CODE_MSB:`DCR_DRIVE_CODE_LSB];
		end
	end

	always_ff @(posedge mclk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			drive_code_q <= `DCR_DRIVE_CODE_RST;
		end else begin
			drive_code_q <= drive_code_d;
		end
	end

	// ----------------------------------------
	// Calibrated drive code
	// ----------------------------------------
	always_comb begin
		cal_code_d = cal_code_q;
		// Correction result dropped while auto amplitude is off
		if (amp_corr_done_i && !autoamp_dis_q) begin
			cal_code_d = amp_corr_code_i;
		end
	end

	always_ff @(posedge mclk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			cal_code_q <= `DCR_CAL_CODE_RST;
		end else begin
			cal_code_q <= cal_code_d;
		end
	end

	// ----------------------------------------
	// Applied drive during settle and conversion
	// ----------------------------------------
	always_comb begin
		drive_d = drive_q;
		// Holds its last value outside channel 3 intervals
		if (ch3_active_i) begin
			drive_d = override_q ? drive_code_q : ch3_auto_code_i;
		end
	end

	always_ff @(posedge mclk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			drive_q <= 5'h00;
		end else begin
			drive_q <= drive_d;
		end
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	// Each output is a register of its own
	always_comb begin
		avs_readdata_o                = rdata_q;
		avs_waitrequest_o             = waitreq_q;
		ch3_drive_o                   = drive_q;
		calibration_override_enable_o = override_q;
		auto_amplitude_disable_o      = autoamp_dis_q;
	end

endmodule : dcr_regs

// File: dcr_params.svh
`ifndef DCR_PARAMS_SVH
`define DCR_PARAMS_SVH

// ----------------------------------------
// Register indices (byte address = 4 * index)
// ----------------------------------------
`define DCR_IDX_CH3_DRIVE     7'h21
`define DCR_IDX_MAKER_ID      7'h7e
`define DCR_IDX_PART_ID       7'h7f
`define DCR_IDX_CONFIG        7'h40

// ----------------------------------------
// Field positions
// ----------------------------------------
`define DCR_DRIVE_CODE_MSB    15
`define DCR_DRIVE_CODE_LSB    11
`define DCR_CAL_CODE_MSB      10
`define DCR_CAL_CODE_LSB      6
`define DCR_CFG_OVERRIDE_BIT  0
`define DCR_CFG_AUTOAMP_BIT   1

// ----------------------------------------
// Reset values
// ----------------------------------------
`define DCR_DRIVE_CODE_RST    5'h00
`define DCR_CAL_CODE_RST      5'h00
`define DCR_CFG_RST           2'h0

// Arbitrary neutral identity values
`define DCR_MAKER_ID_VAL      16'h1234
`define DCR_PART_ID_VAL       8'h5a

`endif

// File: dcr_pkg.sv
package dcr_pkg;

	typedef enum logic [1:0] {
		DCR_IDLE = 2'b01,
		DCR_RESP = 2'b10
	} dcr_state_e;

endpackage : dcr_pkg

// File: dcr_regs_sva.sv
module dcr_regs_sva #(
	parameter logic [15:0] MAKER_ID = 16'h0000,
	parameter logic [7:0]  PART_ID  = 8'h00
) (
	input wire logic        mclk_i,
	input wire logic        rst_b_i,
	input wire logic        avs_read_i,
	input wire logic        avs_write_i,
	input wire logic        avs_waitrequest_o,
	input wire logic [8:0]  avs_address_i,
	input wire logic [31:0] avs_readdata_o,
	input wire logic        ch3_active_i,
	input wire logic        calibration_override_enable_o,
	input wire logic [4:0]  ch3_auto_code_i,
	input wire logic [4:0]  ch3_drive_o
);
	// ----
	// Bus and drive checks
	// ----
	default clocking @(posedge mclk_i); endclocking
	default disable iff (!rst_b_i);
	chk_one_answer: assert property ((avs_read_i || avs_write_i) && avs_waitrequest_o
		|=> !avs_waitrequest_o ##1 avs_waitrequest_o) else $error("answer timing wrong");
	chk_no_answer: assert property (!(avs_read_i || avs_write_i) && avs_waitrequest_o
		|=> avs_waitrequest_o) else $error("answer without request");
	chk_rsv_zero: assert property (!avs_waitrequest_o && avs_read_i && avs_address_i[8:2] == 7'h21
		|-> avs_readdata_o[31:16] == 16'h0000 && avs_readdata_o[5:0] == 6'h00) else $error("reserved bits set");
	chk_maker_val: assert property (!avs_waitrequest_o && avs_read_i && avs_address_i[8:2] == 7'h7e
		|-> avs_readdata_o == {16'h0000, MAKER_ID}) else $error("maker code wrong");
	chk_part_val: assert property (!avs_waitrequest_o && avs_read_i && avs_address_i[8:2] == 7'h7f
		|-> avs_readdata_o == {24'h000000, PART_ID}) else $error("part code wrong");
	chk_idle_zero: assert property (avs_waitrequest_o |-> avs_readdata_o == 32'h00000000)
		else $error("read data outside answer");
	chk_auto_apply: assert property (ch3_active_i && !calibration_override_enable_o
		|=> ch3_drive_o == $past(ch3_auto_code_i)) else $error("auto code not applied");
	chk_drive_hold: assert property (!ch3_active_i |=> $stable(ch3_drive_o))
		else $error("drive moved while idle");
endmodule : dcr_regs_sva

bind dcr_regs dcr_regs_sva #(.MAKER_ID(MAKER_ID), .PART_ID(PART_ID)) dcr_regs_sva_i (.*);

// File: dcr_regs_test.sv
`include "dcr_params.svh"
module dcr_regs_test;
	timeunit 1ns;
	timeprecision 1ns;
	logic mclk_i = 0, rst_b_i = 0, avs_read_i = 0, avs_write_i = 0, avs_waitrequest_o;
	logic ch3_active_i = 0, amp_corr_done_i = 0, calibration_override_enable_o, auto_amplitude_disable_o;
	logic [8:0] avs_address_i = 0;
	logic [31:0] avs_writedata_i = 0, avs_readdata_o, s = 32'h0001_1e80, q[$];
	logic [3:0] avs_byteenable_i = 4'hf;
	logic [4:0] amp_corr_code_i = 0, ch3_auto_code_i = 0, ch3_drive_o, d, c;
	int error_cnt = 0, num_checks = 0;
	dcr_regs dcr_regs_i (.*);
	always #10 mclk_i = ~mclk_i;
	function automatic logic [31:0] nx(input logic [31:0] v);
		return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
	endfunction : nx
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		num_checks++;
		if (g !== e) begin
			$display("[FAIL] %0t got %h exp %h", $time, g, e);
			error_cnt++;
		end
	endtask : chk
	task automatic bus(input logic w, input logic [8:0] a, input logic [31:0] x);
		@(posedge mclk_i);
		avs_write_i <= w;
		avs_read_i <= !w;
		avs_address_i <= a;
		avs_writedata_i <= x;
		do @(posedge mclk_i); while (avs_waitrequest_o !== 1'b0);
		avs_write_i <= 0;
		avs_read_i <= 0;
	endtask : bus
	task automatic rd(input logic [8:0] a, input logic [31:0] e);
		q.push_back(e);
		bus(0, a, 0);
	endtask : rd
	task automatic pulse(input logic [4:0] k);
		@(posedge mclk_i);
		amp_corr_code_i <= k;
		amp_corr_done_i <= 1;
		@(posedge mclk_i);
		amp_corr_done_i <= 0;
	endtask : pulse
	task print_verdict;
		if (error_cnt == 0 && num_checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : print_verdict
	always @(posedge mclk_i) if (avs_read_i && avs_waitrequest_o === 1'b0) chk(avs_readdata_o, q.pop_front());
	initial begin
		repeat (3000) @(posedge mclk_i);
		error_cnt++;
		print_verdict;
	end
	initial begin
		repeat (10) @(posedge mclk_i);
		rst_b_i <= 1;
		rd(9'h084, 0);
		bus(1, 9'h1f8, 32'hffffffff);
		bus(1, 9'h1fc, 32'hffffffff);
		rd(9'h1f8, `DCR_MAKER_ID_VAL);
		rd(9'h1fc, `DCR_PART_ID_VAL);
		rd(9'h1f0, 0);
		s = nx(s);
		d = s[15:11];
		bus(1, 9'h084, s | 32'h07ff);
		rd(9'h084, {d, 11'h000});
		avs_byteenable_i <= 4'h1;
		bus(1, 9'h084, 32'h0000_0000);
		avs_byteenable_i <= 4'hf;
		rd(9'h084, {d, 11'h000});
		bus(1, 9'h100, 1);
		ch3_active_i <= 1;
		repeat (3) @(posedge mclk_i);
		chk(ch3_drive_o, d);
		chk(calibration_override_enable_o, 1);
		s = nx(s);
		bus(1, 9'h100, 0);
		ch3_auto_code_i <= s[4:0];
		repeat (3) @(posedge mclk_i);
		chk(ch3_drive_o, s[4:0]);
		c = s[9:5];
		pulse(c);
		rd(9'h084, {d, c, 6'h00});
		bus(1, 9'h100, 2);
		pulse(~c);
		rd(9'h084, {d, c, 6'h00});
		rd(9'h100, 2);
		chk(auto_amplitude_disable_o, 1);
		rst_b_i <= 0;
		repeat (2) @(posedge mclk_i);
		rst_b_i <= 1;
		chk(auto_amplitude_disable_o, 0);
		rd(9'h084, 0);
		print_verdict;
	end
endmodule : dcr_regs_test
